// file: src/mpc_map.svh
// Constants for the motor protection and power-mode controller.
// Assumes inclusion by bare name from the package and the design files.
`ifndef MPC_MAP_SVH
`define MPC_MAP_SVH

// Register byte offsets on the AHB-Lite slave.
`define MPC_OFF_STATUS 8'h00
`define MPC_OFF_MASK 8'h04
`define MPC_OFF_CTRL 8'h08
`define MPC_OFF_FLAGS 8'h0c
`define MPC_OFF_POS 8'h10
`define MPC_OFF_SAFE_POS 8'h14

// Interrupt status and mask bit positions.
`define MPC_IRQ_SLEEP 0
`define MPC_IRQ_SHDN 1
`define MPC_IRQ_TOUT 2
`define MPC_IRQ_WAKE 3
`define MPC_IRQ_W 4

// Control register bit positions.
`define MPC_CTRL_SEC_EN 0

// Flag register bit positions.
`define MPC_FLG_WARN 0
`define MPC_FLG_TSD 1
`define MPC_FLG_UV 2
`define MPC_FLG_LOSS 3
`define MPC_FLG_SHDN 4
`define MPC_FLG_BRIDGE 5
`define MPC_FLG_MODE 6

// Reset values.
`define MPC_RST_MASK 4'h0
`define MPC_RST_CTRL 1'b0

// Bus frame codes for the sleep command.
`define MPC_SLEEP_ID 6'h3c
`define MPC_SLEEP_BYTE 8'h00

// Bus inactivity timeout: bit slots, bit rate, clock rate.
`define MPC_TOUT_SLOTS 25000
`define MPC_BIT_RATE_HZ 19200
`define MPC_CLK_HZ 10000000
`define MPC_CYC_PER_BIT (`MPC_CLK_HZ / `MPC_BIT_RATE_HZ)
`define MPC_TOUT_CYCLES (`MPC_TOUT_SLOTS * `MPC_CYC_PER_BIT)

`endif

// file: src/mpc_pkg.sv
// Types of the motor protection and power-mode controller.
// Assumes the constants header is on the include path.
`include "mpc_map.svh"

package mpc_pkg;

    // Power mode of the controller.
    typedef enum logic [2:0] {
        MPC_NORMAL = 3'b000,
        MPC_GO_SECURE = 3'b001,
        MPC_HALTING = 3'b010,
        MPC_SLEEP = 3'b011,
        MPC_SHUTDOWN = 3'b100,
        MPC_SHD_HALT = 3'b101
    } mpc_mode_t;

endpackage

// file: src/mpc_sync.sv
// Two-flop synchroniser for a vector of asynchronous levels.
// Assumes the inputs come from comparators or pins outside the clock domain.
`timescale 1ns/1ps
`default_nettype none

module mpc_sync #(
    parameter int W = 8
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    // First stage; read only by the second stage.
    logic [W-1:0] meta_q;

    ////////////////////////////////////////////////////////////////////////
    // Each bit passes two flops before any logic looks at it.
    generate
        for (genvar i = 0; i < W; i++) begin : g_bit
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    meta_q[i] <= 1'b0;
                    q[i] <= 1'b0;
                end else begin
                    meta_q[i] <= d[i];
                    q[i] <= meta_q[i];
                end
            end
        end
    endgenerate

endmodule
`default_nettype wire

// file: src/mpc_top.sv
// Protection flags, sleep control and motor shutdown for a bus-slave
// stepper driver.
// Assumes frame decoding, the position controller and the analog
// comparators are outside; comparator levels arrive unsynchronised.
//
// The implementer's own choices: the AHB-Lite register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "mpc_map.svh"

module mpc_top #(
    parameter int TOUT_CYCLES = `MPC_TOUT_CYCLES
) (
    input wire logic CLK,
    input wire logic RST,
    // AHB-Lite slave.
    input wire logic HSEL,
    input wire logic [7:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    // Comparator levels from the analog side.
    input wire logic TEMP_WARN,
    input wire logic TEMP_SHDN,
    input wire logic VBAT_BELOW_UV,
    input wire logic VBAT_ABOVE_RECOVERY,
    input wire logic ELEC_DEFECT,
    input wire logic CPUMP_FAIL,
    input wire logic STEP_LOST,
    // Frame decoder events, one-cycle pulses on CLK.
    input wire logic FRAME_VALID,
    input wire logic [5:0] FRAME_ID,
    input wire logic [7:0] FRAME_DATA0,
    input wire logic STATUS_READ,
    input wire logic BUS_ACTIVITY,
    // Position controller handshake.
    input wire logic MOTION_BUSY,
    input wire logic [15:0] ACTUAL_POSITION,
    // Control outputs.
    output logic BRIDGE_HIZ,
    output logic TARGET_LOAD,
    output logic [15:0] TARGET_POSITION,
    output logic RAMPED_HALT,
    output logic POWER_DOWN,
    output logic BUS_RX_ENABLE,
    output logic BUS_IF_ENABLE,
    output logic IRQ
);

    ////////////////////////////////////////////////////////////////////////
    // Synchronised comparator levels.
    logic [6:0] cmp_raw;
    logic [6:0] cmp;
    assign cmp_raw = {STEP_LOST, CPUMP_FAIL, ELEC_DEFECT,
                      VBAT_ABOVE_RECOVERY, VBAT_BELOW_UV, TEMP_SHDN,
                      TEMP_WARN};

    mpc_sync #(.W(7)) u_sync (
        .clk(CLK),
        .rst(RST),
        .d(cmp_raw),
        .q(cmp)
    );

    logic warn_in, tsd_in, uv_in, rec_in, eldef_in, cpf_in, loss_in;
    assign warn_in = cmp[0];
    assign tsd_in = cmp[1];
    assign uv_in = cmp[2];
    assign rec_in = cmp[3];
    assign eldef_in = cmp[4];
    assign cpf_in = cmp[5];
    assign loss_in = cmp[6];

    ////////////////////////////////////////////////////////////////////////
    // State and registers.
    mpc_pkg::mpc_mode_t mode_q; // Power mode.
    logic thermal_warning_flag_q; // Warning flag.
    logic tsd_flag_q; // Thermal shutdown flag.
    logic undervoltage_flag_q; // Battery below the shutdown level.
    logic step_loss_q; // Missed-step flag.
    // Bus inactivity counter; 24 bits hold the full-length limit.
    logic [23:0] idle_cnt_q;
    logic tout_q; // Inactivity timeout level.
    logic sec_en_q; // Secure position enable.
    logic [10:0] secure_target_position_q; // Secure position, 11 MSBs.
    logic [3:0] irq_stat_q; // Sticky event bits.
    logic [3:0] irq_mask_q; // Interrupt enables.

    // Decoded frame events.
    logic sleep_cmd;
    logic any_cause;
    assign sleep_cmd = FRAME_VALID && (FRAME_ID == `MPC_SLEEP_ID) &&
                       (FRAME_DATA0 == `MPC_SLEEP_BYTE);
    // Causes come from the synchronised comparators only, not the latched flags.
    assign any_cause = tsd_in || uv_in || eldef_in || cpf_in;

    ////////////////////////////////////////////////////////////////////////
    // Thermal flags latch on detection, clear only when cool and read.
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            thermal_warning_flag_q <= 1'b0;
            tsd_flag_q <= 1'b0;
        end else begin
            if (STATUS_READ && !warn_in) begin
                thermal_warning_flag_q <= 1'b0;
                tsd_flag_q <= 1'b0;
            end
            if (warn_in) begin
                thermal_warning_flag_q <= 1'b1;
            end
            if (tsd_in) begin
                tsd_flag_q <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Voltage and step-loss flags.
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            undervoltage_flag_q <= 1'b0;
            step_loss_q <= 1'b0;
        end else begin
            if (STATUS_READ && rec_in) begin
                undervoltage_flag_q <= 1'b0;
                step_loss_q <= 1'b0;
            end
            if (uv_in) begin
                undervoltage_flag_q <= 1'b1;
            end
            if (loss_in && mode_q != mpc_pkg::MPC_SHUTDOWN &&
                mode_q != mpc_pkg::MPC_SHD_HALT) begin
                step_loss_q <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Bus inactivity timer. The count is long, so the limit is a
    // parameter that a simulation may shorten.
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            idle_cnt_q <= 24'h000000;
            tout_q <= 1'b0;
        end else if (BUS_ACTIVITY || FRAME_VALID) begin
            idle_cnt_q <= 24'h000000;
            tout_q <= 1'b0;
        end else if (idle_cnt_q >= 24'(TOUT_CYCLES)) begin
            tout_q <= 1'b1;
        end else begin
            idle_cnt_q <= idle_cnt_q + 24'h000001;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Mode state machine. Shutdown has priority over sleep entry,
    // except that bus loss or a sleep command during shutdown goes straight to sleep.
    logic tout_rise;
    logic tout_d1_q;
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            tout_d1_q <= 1'b0;
        end else begin
            tout_d1_q <= tout_q;
        end
    end
    assign tout_rise = tout_q && !tout_d1_q;

    logic go_sleep;
    assign go_sleep = sleep_cmd || tout_rise;

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            // After power-up the device sits in shutdown.
            mode_q <= mpc_pkg::MPC_SHUTDOWN;
        end else begin
            case (mode_q)
                mpc_pkg::MPC_NORMAL: begin
                    if (tsd_in && MOTION_BUSY) begin
                        mode_q <= mpc_pkg::MPC_SHD_HALT;
                    end else if (any_cause) begin
                        mode_q <= mpc_pkg::MPC_SHUTDOWN;
                    end else if (go_sleep && MOTION_BUSY) begin
                        mode_q <= sec_en_q ? mpc_pkg::MPC_GO_SECURE
                                           : mpc_pkg::MPC_HALTING;
                    end else if (go_sleep) begin
                        mode_q <= mpc_pkg::MPC_SLEEP;
                    end
                end
                mpc_pkg::MPC_GO_SECURE, mpc_pkg::MPC_HALTING: begin
                    if (any_cause) begin
                        mode_q <= mpc_pkg::MPC_SHUTDOWN;
                    end else if (FRAME_VALID && !sleep_cmd) begin
                        mode_q <= mpc_pkg::MPC_NORMAL;
                    end else if (!MOTION_BUSY) begin
                        mode_q <= mpc_pkg::MPC_SLEEP;
                    end
                end
                mpc_pkg::MPC_SHD_HALT: begin
                    if (!MOTION_BUSY) begin
                        mode_q <= mpc_pkg::MPC_SHUTDOWN;
                    end
                end
                mpc_pkg::MPC_SHUTDOWN: begin
                    if (tout_rise || sleep_cmd) begin
                        mode_q <= mpc_pkg::MPC_SLEEP;
                    end else if (STATUS_READ && !any_cause) begin
                        mode_q <= mpc_pkg::MPC_NORMAL;
                    end
                end
                mpc_pkg::MPC_SLEEP: begin
                    // A dominant level or frame wakes the device.
                    if (BUS_ACTIVITY || FRAME_VALID) begin
                        mode_q <= mpc_pkg::MPC_NORMAL;
                    end
                end
                default: begin
                    mode_q <= mpc_pkg::MPC_SHUTDOWN;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Motor and bus control outputs, registered from the mode.
    logic in_shd;
    assign in_shd = (mode_q == mpc_pkg::MPC_SHUTDOWN);

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            BRIDGE_HIZ <= 1'b1;
            TARGET_LOAD <= 1'b0;
            TARGET_POSITION <= 16'h0000;
            RAMPED_HALT <= 1'b0;
            POWER_DOWN <= 1'b0;
            BUS_RX_ENABLE <= 1'b1;
            BUS_IF_ENABLE <= 1'b1;
        end else begin
            BRIDGE_HIZ <= in_shd || (mode_q == mpc_pkg::MPC_SLEEP);
            TARGET_LOAD <= in_shd;
            if (mode_q == mpc_pkg::MPC_GO_SECURE) begin
                TARGET_LOAD <= 1'b1;
                TARGET_POSITION <= {secure_target_position_q, 5'h00};
            end else begin
                TARGET_POSITION <= ACTUAL_POSITION;
            end
            RAMPED_HALT <= (mode_q == mpc_pkg::MPC_HALTING) ||
                           (mode_q == mpc_pkg::MPC_SHD_HALT);
            POWER_DOWN <= (mode_q == mpc_pkg::MPC_SLEEP);
            BUS_RX_ENABLE <= 1'b1;
            BUS_IF_ENABLE <= (mode_q != mpc_pkg::MPC_SLEEP);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt events, sticky, write one to clear; set wins.
    logic [3:0] ev;
    logic [3:0] w1c;
    assign ev[`MPC_IRQ_SLEEP] = POWER_DOWN == 1'b0 &&
                                mode_q == mpc_pkg::MPC_SLEEP;
    assign ev[`MPC_IRQ_SHDN] = BRIDGE_HIZ == 1'b0 && in_shd;
    assign ev[`MPC_IRQ_TOUT] = tout_rise;
    assign ev[`MPC_IRQ_WAKE] = POWER_DOWN && mode_q != mpc_pkg::MPC_SLEEP;

    ////////////////////////////////////////////////////////////////////////
    // AHB-Lite slave: zero wait states, always OKAY.
    logic wr_pend_q;
    logic [7:0] wr_addr_q;
    logic rd_go;
    assign rd_go = HSEL && HREADY && HTRANS[1] && !HWRITE;
    assign w1c = (wr_pend_q && wr_addr_q == `MPC_OFF_STATUS)
                 ? HWDATA[3:0] : 4'h0;

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
        end else if (HREADY) begin
            wr_pend_q <= HSEL && HTRANS[1] && HWRITE;
            wr_addr_q <= HADDR;
        end
    end

    // Writable registers.
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            irq_mask_q <= `MPC_RST_MASK;
            sec_en_q <= `MPC_RST_CTRL;
            secure_target_position_q <= 11'h000;
        end else if (wr_pend_q) begin
            case (wr_addr_q)
                `MPC_OFF_MASK: irq_mask_q <= HWDATA[3:0];
                `MPC_OFF_CTRL: sec_en_q <= HWDATA[`MPC_CTRL_SEC_EN];
                `MPC_OFF_SAFE_POS: secure_target_position_q <= HWDATA[10:0];
                default: begin
                end
            endcase
        end
    end

    // Sticky status.
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            irq_stat_q <= 4'h0;
        end else begin
            irq_stat_q <= (irq_stat_q & ~w1c) | ev;
        end
    end

    // Read data, registered in the address phase.
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            HRDATA <= 32'h00000000;
        end else if (rd_go) begin
            case (HADDR)
                `MPC_OFF_STATUS: HRDATA <= {28'h0, irq_stat_q};
                `MPC_OFF_MASK: HRDATA <= {28'h0, irq_mask_q};
                `MPC_OFF_CTRL: HRDATA <= {31'h0, sec_en_q};
                `MPC_OFF_FLAGS: HRDATA <= {23'h0, mode_q, BRIDGE_HIZ,
                    in_shd, step_loss_q, undervoltage_flag_q,
                    tsd_flag_q, thermal_warning_flag_q};
                `MPC_OFF_POS: HRDATA <= {16'h0, TARGET_POSITION};
                `MPC_OFF_SAFE_POS: HRDATA <= {21'h0,
                    secure_target_position_q};
                default: HRDATA <= 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            HREADYOUT <= 1'b1;
            HRESP <= 1'b0;
            IRQ <= 1'b0;
        end else begin
            HREADYOUT <= 1'b1;
            HRESP <= 1'b0;
            IRQ <= |(irq_stat_q & irq_mask_q);
        end
    end

endmodule
`default_nettype wire

// file: tb/mpc_lin_master.sv
// Behavioural bus master as seen through the frame decoder.
// Assumes the bench calls its tasks right after a rising clock edge.
`timescale 1ns/1ps
`default_nettype none

module mpc_lin_master #(
    parameter int MAX_TRIES = 4
) (
    input wire logic CLK,
    input wire logic RST,
    input wire logic alive,
    output logic FRAME_VALID,
    output logic [5:0] FRAME_ID,
    output logic [7:0] FRAME_DATA0,
    output logic STATUS_READ,
    output logic BUS_ACTIVITY
);
    logic [2:0] tick_q;
    int tries;

    initial begin
        {FRAME_VALID, STATUS_READ, BUS_ACTIVITY} = 3'h0;
        FRAME_ID = 6'h0;
        FRAME_DATA0 = 8'h0;
        tick_q = 3'h0;
        tries = 0;
    end

    // Bus edges every eight cycles while alive; silence lets it time out.
    always @(posedge CLK) begin
        tick_q <= RST ? 3'h0 : tick_q + 3'h1;
        BUS_ACTIVITY <= alive && !RST && tick_q == 3'h7;
    end

    // frame sent with the given id and data
    // A frame lasts one cycle; the fields then show their inverse.
    task automatic frame(input logic [5:0] id, input logic [7:0] d0);
        FRAME_ID <= id;
        FRAME_DATA0 <= d0;
        FRAME_VALID <= 1'b1;
        tries = 0;
        @(posedge CLK);
        FRAME_VALID <= 1'b0;
        FRAME_ID <= ~id;
        FRAME_DATA0 <= ~d0;
    endtask

    // limited release attempts
    // Gives up after a few status reads in a row, sparing the bridges.
    task automatic status();
        if (tries < MAX_TRIES) begin
            STATUS_READ <= 1'b1;
            @(posedge CLK);
            STATUS_READ <= 1'b0;
        end
        tries++;
    endtask
endmodule
`default_nettype wire

// file: tb/mpc_top_sva.sv
// Port checker for the protection and power-mode controller.
// Assumes the design's register latencies and one clock domain.
`timescale 1ns/1ps
`default_nettype none

module mpc_top_sva #(
    parameter int TOUT_CYCLES = 50
) (
    input wire logic CLK,
    input wire logic RST,
    input wire logic TEMP_SHDN,
    input wire logic VBAT_BELOW_UV,
    input wire logic ELEC_DEFECT,
    input wire logic CPUMP_FAIL,
    input wire logic FRAME_VALID,
    input wire logic [5:0] FRAME_ID,
    input wire logic [7:0] FRAME_DATA0,
    input wire logic STATUS_READ,
    input wire logic BUS_ACTIVITY,
    input wire logic MOTION_BUSY,
    input wire logic [15:0] ACTUAL_POSITION,
    input wire logic BRIDGE_HIZ,
    input wire logic [15:0] TARGET_POSITION,
    input wire logic RAMPED_HALT,
    input wire logic POWER_DOWN,
    input wire logic BUS_RX_ENABLE,
    input wire logic BUS_IF_ENABLE
);
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RST);

    ////////////////////////////////////////////////////////////////////////
    // Idle cycles since the bus last showed life; saturates with margin.
    int idle_q;
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            idle_q <= 0;
        end else if (BUS_ACTIVITY || FRAME_VALID || STATUS_READ) begin
            idle_q <= 0;
        end else if (idle_q < TOUT_CYCLES + 8) begin
            idle_q <= idle_q + 1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    a_rx_on: assert property (BUS_RX_ENABLE)
        else $error("bus receiver switched off");
    a_if_alive: assert property (BRIDGE_HIZ && !POWER_DOWN
        |-> BUS_IF_ENABLE) else $error("bus interface off while shut down");
    a_sleep_frame: assert property (FRAME_VALID && FRAME_ID == 6'h3c
        && FRAME_DATA0 == 8'h00 && !MOTION_BUSY && !POWER_DOWN
        |-> ##[1:4] POWER_DOWN) else $error("sleep frame ignored");
    a_shdn_cause: assert property ((ELEC_DEFECT || CPUMP_FAIL
        || VBAT_BELOW_UV) [*4] ##0 !POWER_DOWN |-> ##[0:3] BRIDGE_HIZ)
        else $error("shutdown cause without high impedance");
    a_target_copy: assert property ($rose(BRIDGE_HIZ) && !POWER_DOWN
        |-> ##[0:2] TARGET_POSITION == ACTUAL_POSITION)
        else $error("target not loaded from actual position");
    a_stay_shut: assert property (BRIDGE_HIZ && !POWER_DOWN
        && !STATUS_READ && !$past(STATUS_READ) |=> BRIDGE_HIZ)
        else $error("shutdown left without status read");
    a_idle_sleep: assert property (idle_q == TOUT_CYCLES + 8
        && !MOTION_BUSY |-> POWER_DOWN) else $error("no sleep on silence");
    a_halt_first: assert property (TEMP_SHDN [*5] ##0 (MOTION_BUSY
        && !BRIDGE_HIZ && !POWER_DOWN) |-> RAMPED_HALT)
        else $error("no ramped halt before thermal shutdown");

    c_sleep: cover property ($rose(POWER_DOWN));
    c_shdn: cover property ($rose(BRIDGE_HIZ));
    c_halt: cover property ($rose(RAMPED_HALT));
endmodule

bind mpc_top mpc_top_sva #(.TOUT_CYCLES(TOUT_CYCLES)) u_mpc_top_sva (.*);
`default_nettype wire

// file: tb/tb_mpc_top.sv
// Self-checking bench for the protection and power-mode controller.
// Assumes a zero-wait AHB-Lite slave and a shortened bus timeout.
`timescale 1ns/1ps
`default_nettype none
`include "mpc_map.svh"

module tb_mpc_top;
    localparam int TOUT = 50;
    logic CLK = 1'b0;
    logic RST, HSEL, HWRITE, HREADY, HREADYOUT, HRESP, alive;
    logic [7:0] HADDR, FRAME_DATA0;
    logic [1:0] HTRANS;
    logic [2:0] HSIZE;
    logic [31:0] HWDATA, HRDATA, rdata;
    logic TEMP_WARN, TEMP_SHDN, VBAT_BELOW_UV, VBAT_ABOVE_RECOVERY;
    logic ELEC_DEFECT, CPUMP_FAIL, STEP_LOST, MOTION_BUSY, IRQ;
    logic FRAME_VALID, STATUS_READ, BUS_ACTIVITY, TARGET_LOAD;
    logic [5:0] FRAME_ID;
    logic [15:0] ACTUAL_POSITION, TARGET_POSITION;
    logic BRIDGE_HIZ, RAMPED_HALT, POWER_DOWN, BUS_RX_ENABLE, BUS_IF_ENABLE;
    logic [3:0] cz;
    int failures, comparisons, cycles;

    // The single slave's ready is the bus ready.
    assign HREADY = HREADYOUT;
    assign {TEMP_SHDN, VBAT_BELOW_UV, ELEC_DEFECT, CPUMP_FAIL} = cz;
    always #50 CLK = ~CLK;

    mpc_top #(.TOUT_CYCLES(TOUT)) u_mpc_top (.*);
    mpc_lin_master u_mpc_lin_master (.*);

    ////////////////////////////////////////////////////////////////////////
    task automatic end_sim();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // A hang is cut short well beyond the expected run length.
    always @(posedge CLK) begin
        cycles++;
        if (cycles > 5000) begin
            failures++;
            end_sim();
        end
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge CLK);
    endtask

    task automatic chk(input string n, input logic [31:0] e, g);
        comparisons++;
        if (g !== e) begin
            failures++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask

    task automatic cb(input string n, input logic e, g);
        chk(n, {31'h0, e}, {31'h0, g});
    endtask

    // One single word transfer; read data lands in rdata.
    task automatic xfer(input logic [7:0] a, input logic w,
                        input logic [31:0] d);
        HSEL <= 1'b1;
        HADDR <= a;
        HWRITE <= w;
        HTRANS <= 2'b10;
        do @(posedge CLK); while (HREADY !== 1'b1);
        HTRANS <= 2'b00;
        HSEL <= 1'b0;
        HWDATA <= d;
        do @(posedge CLK); while (HREADY !== 1'b1);
        rdata = HRDATA;
    endtask

    task automatic md(input logic [2:0] m);
        xfer(`MPC_OFF_FLAGS, 1'b0, 32'h0);
        chk("mode", {29'h0, m}, {29'h0, rdata[8:6]});
    endtask

    task automatic fl(input int b, input logic e);
        xfer(`MPC_OFF_FLAGS, 1'b0, 32'h0);
        cb("flag", e, rdata[b]);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        {RST, HSEL, HWRITE, HADDR, HTRANS, HWDATA} = 1'b1 << 44;
        HSIZE = 3'b010;
        {TEMP_WARN, STEP_LOST, MOTION_BUSY, cz} = 7'h0;
        VBAT_ABOVE_RECOVERY = 1'b1;
        ACTUAL_POSITION = 16'h1234;
        alive = 1'b1;
        cyc(3);
        RST <= 1'b0;
        cyc(1);
        md(mpc_pkg::MPC_SHUTDOWN);
        cb("hiz", 1'b1, BRIDGE_HIZ);
        cb("hresp", 1'b0, HRESP);
        xfer(8'h20, 1'b1, 32'hffffffff);
        xfer(8'h20, 1'b0, 32'h0);
        chk("unmapped", 32'h0, rdata);
        xfer(`MPC_OFF_MASK, 1'b0, 32'h0);
        chk("mask", 32'h0, rdata);
        u_mpc_lin_master.status();
        cyc(3);
        md(mpc_pkg::MPC_NORMAL);
        cb("hiz", 1'b0, BRIDGE_HIZ);
        for (int i = 0; i < 4; i++) begin
            cz <= 4'h1 << i;
            cyc(8);
            md(mpc_pkg::MPC_SHUTDOWN);
            chk("target", 32'h1234, {16'h0, TARGET_POSITION});
            cb("load", 1'b1, TARGET_LOAD);
            STEP_LOST <= 1'b1;
            cyc(4);
            STEP_LOST <= 1'b0;
            fl(`MPC_FLG_LOSS, 1'b0);
            u_mpc_lin_master.status();
            cyc(3);
            md(mpc_pkg::MPC_SHUTDOWN);
            cz <= 4'h0;
            cyc(4);
            u_mpc_lin_master.status();
            cyc(3);
            md(mpc_pkg::MPC_NORMAL);
            u_mpc_lin_master.frame(6'h10, 8'h01);
        end
        $display("test reset and shutdown done");
        TEMP_WARN <= 1'b1;
        cyc(4);
        fl(`MPC_FLG_WARN, 1'b1);
        u_mpc_lin_master.status();
        cyc(2);
        fl(`MPC_FLG_WARN, 1'b1);
        TEMP_WARN <= 1'b0;
        cyc(6);
        fl(`MPC_FLG_WARN, 1'b1);
        u_mpc_lin_master.status();
        cyc(2);
        fl(`MPC_FLG_WARN, 1'b0);
        VBAT_ABOVE_RECOVERY <= 1'b0;
        STEP_LOST <= 1'b1;
        cyc(4);
        STEP_LOST <= 1'b0;
        u_mpc_lin_master.status();
        cyc(2);
        fl(`MPC_FLG_LOSS, 1'b1);
        VBAT_ABOVE_RECOVERY <= 1'b1;
        cyc(4);
        u_mpc_lin_master.status();
        cyc(2);
        fl(`MPC_FLG_LOSS, 1'b0);
        $display("test flags done");
        xfer(`MPC_OFF_STATUS, 1'b1, 32'hf);
        alive <= 1'b0;
        u_mpc_lin_master.frame(`MPC_SLEEP_ID, `MPC_SLEEP_BYTE);
        cyc(4);
        md(mpc_pkg::MPC_SLEEP);
        cb("pdn", 1'b1, POWER_DOWN);
        cb("ifen", 1'b0, BUS_IF_ENABLE);
        cb("rx", 1'b1, BUS_RX_ENABLE);
        cb("irq", 1'b0, IRQ);
        xfer(`MPC_OFF_MASK, 1'b1, 32'h1);
        cyc(2);
        cb("irq", 1'b1, IRQ);
        xfer(`MPC_OFF_STATUS, 1'b1, 32'h1);
        cyc(2);
        cb("irq", 1'b0, IRQ);
        alive <= 1'b1;
        cyc(12);
        md(mpc_pkg::MPC_NORMAL);
        $display("test sleep done");
        xfer(`MPC_OFF_SAFE_POS, 1'b1, 32'h123);
        xfer(`MPC_OFF_CTRL, 1'b1, 32'h1);
        MOTION_BUSY <= 1'b1;
        alive <= 1'b0;
        u_mpc_lin_master.frame(`MPC_SLEEP_ID, `MPC_SLEEP_BYTE);
        cyc(3);
        md(mpc_pkg::MPC_GO_SECURE);
        chk("target", 32'h2460, {16'h0, TARGET_POSITION});
        xfer(`MPC_OFF_POS, 1'b0, 32'h0);
        chk("pos", 32'h2460, rdata);
        u_mpc_lin_master.frame(6'h10, 8'h01);
        cyc(3);
        md(mpc_pkg::MPC_NORMAL);
        xfer(`MPC_OFF_CTRL, 1'b1, 32'h0);
        u_mpc_lin_master.frame(`MPC_SLEEP_ID, `MPC_SLEEP_BYTE);
        cyc(3);
        md(mpc_pkg::MPC_HALTING);
        cb("halt", 1'b1, RAMPED_HALT);
        MOTION_BUSY <= 1'b0;
        cyc(4);
        md(mpc_pkg::MPC_SLEEP);
        alive <= 1'b1;
        cyc(12);
        $display("test sleep entry done");
        MOTION_BUSY <= 1'b1;
        cz <= 4'h8;
        cyc(6);
        md(mpc_pkg::MPC_SHD_HALT);
        MOTION_BUSY <= 1'b0;
        cyc(4);
        md(mpc_pkg::MPC_SHUTDOWN);
        alive <= 1'b0;
        cyc(TOUT + 10);
        md(mpc_pkg::MPC_SLEEP);
        cz <= 4'h0;
        alive <= 1'b1;
        cyc(12);
        alive <= 1'b0;
        cyc(TOUT + 10);
        md(mpc_pkg::MPC_SLEEP);
        xfer(`MPC_OFF_STATUS, 1'b0, 32'h0);
        cb("tout", 1'b1, rdata[`MPC_IRQ_TOUT]);
        $display("test timeout done");
        end_sim();
    end
endmodule
`default_nettype wire
